// ===== design/rsf_defines.svh
/*
  Constants of the ranging segment framer: status codes, bit positions, usage codes, segment lengths.
  Assumes inclusion by bare name from the package and the framer.
*/
`ifndef RSF_DEFINES_SVH
`define RSF_DEFINES_SVH

// version code in status bits 7:6 of both segments
`define RSF_VERSION 2'h0
// interval usage codes that carry ranging bursts
`define RSF_USAGE_RNG_A 4'h3
`define RSF_USAGE_RNG_B 4'h4
// header status bit positions
`define RSF_HS_TYPE 5
`define RSF_HS_NOPAY 4
`define RSF_HS_HDR_CHK 1
`define RSF_HS_CRC 0
// trailer status bit positions
`define RSF_TS_MOD_RATIO 5
`define RSF_TS_TIME 4
`define RSF_TS_FREQ 3
`define RSF_TS_BIN 2
`define RSF_TS_VND 0
// burst status bit positions
`define RSF_BS_RNG 7
`define RSF_BS_PRE 6
`define RSF_BS_POST 5
// bit position of each segment's status byte inside the shift register
`define RSF_HDR_STAT_LSB 184
`define RSF_TRL_STAT_LSB 120
// shift register width: 64-bit header then 128-bit trailer
`define RSF_SH_W 192
// last byte index of each segment
`define RSF_HDR_LAST 6'h07
`define RSF_TRL_LAST 6'h0B
`define RSF_TRL_LAST_V 6'h0F
// vendor content ceiling in bytes
`define RSF_VND_MAX 6'h20

`endif

// ===== design/rsf_pkg.sv
/*
  Types of the ranging segment framer: state enum and the register struct of the framer.
  Assumes rsf_defines.svh on the include path.
*/
`include "rsf_defines.svh"

package rsf_pkg;

  typedef enum logic [2:0] {
    rsf_idle = 3'h0,
    rsf_hdr = 3'h1,
    rsf_pay = 3'h3,
    rsf_trl = 3'h2,
    rsf_vnd = 3'h6
  } rsf_state_t;

  typedef struct packed {
    rsf_state_t state;
    logic [`RSF_SH_W-1:0] sh;
    logic [5:0] idx;
    logic vend;
    logic [5:0] vlen;
    logic nopay;
    logic out_valid;
    logic [7:0] out_data;
    logic out_sop;
    logic out_eop;
    logic desc_ready;
    logic pay_ready;
    logic divert;
  } rsf_regs_t;

endpackage

// ===== design/rsf_vnd_if.sv
/*
  Interface between the framer and its vendor content store: one write port, one read port.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/10ps

interface rsf_vnd_if #(parameter int AW = 5);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;

  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
  modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface

// ===== design/rsf_vnd_store.sv
/*
  Vendor content store: DEPTH bytes, synchronous write, combinational read.
  Assumes writes happen while no frame reads the store.
*/
`timescale 1ns/10ps

module rsf_vnd_store #(
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // store side
  rsf_vnd_if.store vif
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } rsf_vmem_t;

  rsf_vmem_t st;
  rsf_vmem_t next_st;

  always_comb begin
    next_st = st;
    if (vif.wr_en) begin
      next_st.mem[vif.wr_addr] = vif.wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign vif.rd_data = st.mem[vif.rd_addr];

endmodule

// ===== design/rsf_framer.sv
/*
  Ranging segment framer: builds header and trailer around each ranging burst, one unit per frame.
  Assumes descriptor, payload and vendor write ports come from logic on sys_clk; out_ready from the
  packetiser on the same clock.
*/
`timescale 1ns/10ps
`include "rsf_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - header status bits 7:6 hold version 00; bits 3:2 stay zero.
// - header status bit 5 is 0 for fine, 1 for initial ranging.
// - fine ranging: header bit 4 set when no burst, no payload follows.
// - fine ranging: header bit 1 reports header check sequence failure.
// - header bit 0 reports CRC failure for both ranging types.
// - a zero bit then the 4-bit interval usage code follow the status.
// - the 14-bit scheduled service identifier follows.
// - the 32-bit start minislot follows; 5 zero bits end the header.
// - trailer bit 5 flags a valid modulation error ratio; bits 7:6 carry the version.
// - trailer bit 4 flags a valid timing error.
// - trailer bit 3 flags a valid frequency error.
// - trailer bit 2 flags a valid burst power bin.
// - trailer bit 0 set exactly when vendor fields are appended; bit 1 zero.
// - burst status bit 7 set when further ranging is required.
// - burst status bits 6:5 give 00 pass, 10 pre fail, 11 both fail.
// - burst status bits 2:0 carry the power bin; 16 zero bits follow.
// - modulation error ratio carried as unsigned 8 bits in quarter dB.
// - power error carried as signed 8 bits in quarter dB.
// - frequency error carried as signed 16 bits in hertz.
// - timing error carried as signed 32 bits in 204.8 MHz periods.
// - with vendor flag, three identifier bytes and a length at most 32.
// - exactly length vendor content bytes follow, only with vendor flag.
// - ranging bursts on enabled channels go here, never to the data tunnel.
// - each unit is one whole frame, never split nor merged.
module rsf_framer
  import rsf_pkg::*;
#(
  parameter int VND_DEPTH = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // channel configuration
  input wire logic rng_pw_enable,
  // burst descriptor
  input wire logic desc_valid,
  output logic desc_ready,
  input wire logic desc_initial,
  input wire logic desc_no_burst,
  input wire logic desc_hdr_chk_fail,
  input wire logic desc_crc_fail,
  input wire logic [3:0] desc_usage_code,
  input wire logic [13:0] desc_service_id,
  input wire logic [31:0] desc_minislot,
  // burst measurements
  input wire logic desc_mod_ratio_ok,
  input wire logic [7:0] desc_mod_ratio,
  input wire logic [7:0] desc_pwr_err,
  input wire logic desc_freq_ok,
  input wire logic [15:0] desc_freq_err,
  input wire logic desc_time_ok,
  input wire logic [31:0] desc_time_err,
  input wire logic desc_bin_ok,
  input wire logic [2:0] desc_bin,
  input wire logic desc_reranging,
  input wire logic desc_pre_fail,
  input wire logic desc_post_fail,
  // vendor extension
  input wire logic desc_vendor,
  input wire logic [23:0] desc_org_id,
  input wire logic [5:0] desc_vlen,
  input wire logic vnd_wr_en,
  input wire logic [4:0] vnd_wr_addr,
  input wire logic [7:0] vnd_wr_data,
  // payload in
  input wire logic pay_valid,
  input wire logic [7:0] pay_data,
  input wire logic pay_last,
  output logic pay_ready,
  // frame out
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_sop,
  output logic out_eop,
  input wire logic out_ready,
  // bursts handed to the data tunnel
  output logic data_pw_divert
);

  rsf_regs_t st;
  rsf_regs_t next_st;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  //////////////////////////////////////////////////////////////////////////////
  // vendor store

  rsf_vnd_if #(.AW(5)) vif ();

  assign vif.wr_en = vnd_wr_en;
  assign vif.wr_addr = vnd_wr_addr;
  assign vif.wr_data = vnd_wr_data;
  assign vif.rd_addr = st.idx[4:0];

  rsf_vnd_store #(.DEPTH(VND_DEPTH)) u_store (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .vif(vif)
  );

  //////////////////////////////////////////////////////////////////////////////
  // segment assembly

  logic rng_hit;
  logic take;
  logic nopay_w;
  logic [7:0] hdr_stat;
  logic [7:0] trl_stat;
  logic [7:0] burst_stat;
  logic [63:0] hdr;
  logic [127:0] trl;
  logic [5:0] vlen_c;

  assign rng_hit = rng_pw_enable && (desc_usage_code == `RSF_USAGE_RNG_A ||
                                     desc_usage_code == `RSF_USAGE_RNG_B);
  assign take = (st.state == rsf_idle) && desc_valid && st.desc_ready;
  assign nopay_w = !desc_initial && desc_no_burst;
  assign hdr_stat = {`RSF_VERSION, desc_initial, nopay_w, 2'h0,
                     !desc_initial && desc_hdr_chk_fail, desc_crc_fail};
  assign hdr = {hdr_stat, 1'b0, desc_usage_code, desc_service_id, desc_minislot, 5'h00};
  assign trl_stat = {`RSF_VERSION, desc_mod_ratio_ok, desc_time_ok, desc_freq_ok,
                     desc_bin_ok, 1'b0, desc_vendor};
  assign burst_stat = {desc_reranging, desc_pre_fail || desc_post_fail, desc_post_fail,
                       2'h0, desc_bin};
  assign vlen_c = (desc_vlen > `RSF_VND_MAX) ? `RSF_VND_MAX : desc_vlen;
  assign trl = {trl_stat, burst_stat, 16'h0000, desc_mod_ratio, desc_pwr_err,
                desc_freq_err, desc_time_err, desc_org_id, 2'h0, vlen_c};

  //////////////////////////////////////////////////////////////////////////////
  // frame sequencer

  logic slot;
  logic vnd_more;
  logic last;

  always_comb begin
    next_st = st;
    next_st.divert = 1'b0;
    next_st.out_valid = st.out_valid && !out_ready;
    slot = !st.out_valid || out_ready;
    vnd_more = st.vend && (st.vlen != 6'h00);
    last = 1'b0;
    case (st.state)
      rsf_idle: begin
        if (take) begin
          if (rng_hit) begin
            next_st.sh = {hdr, trl};
            next_st.idx = 6'h00;
            next_st.vend = desc_vendor;
            next_st.vlen = vlen_c;
            next_st.nopay = nopay_w;
            next_st.state = rsf_hdr;
          end else begin
            next_st.divert = 1'b1;
          end
        end
      end
      rsf_hdr: begin
        if (slot) begin
          last = (st.idx == `RSF_HDR_LAST);
          next_st.out_valid = 1'b1;
          next_st.out_data = st.sh[`RSF_SH_W-1 -: 8];
          next_st.out_sop = (st.idx == 6'h00);
          next_st.out_eop = 1'b0;
          next_st.sh = {st.sh[`RSF_SH_W-9:0], 8'h00};
          next_st.idx = last ? 6'h00 : st.idx + 6'h01;
          if (last) begin
            next_st.state = st.nopay ? rsf_trl : rsf_pay;
          end
        end
      end
      rsf_pay: begin
        if (st.pay_ready && pay_valid) begin
          next_st.out_valid = 1'b1;
          next_st.out_data = pay_data;
          next_st.out_sop = 1'b0;
          next_st.out_eop = 1'b0;
          if (pay_last) begin
            next_st.state = rsf_trl;
          end
        end
      end
      rsf_trl: begin
        if (slot) begin
          last = (st.idx == (st.vend ? `RSF_TRL_LAST_V : `RSF_TRL_LAST));
          next_st.out_valid = 1'b1;
          next_st.out_data = st.sh[`RSF_SH_W-1 -: 8];
          next_st.out_sop = 1'b0;
          next_st.out_eop = last && !vnd_more;
          next_st.sh = {st.sh[`RSF_SH_W-9:0], 8'h00};
          next_st.idx = last ? 6'h00 : st.idx + 6'h01;
          if (last) begin
            next_st.state = vnd_more ? rsf_vnd : rsf_idle;
          end
        end
      end
      rsf_vnd: begin
        if (slot) begin
          last = (st.idx == st.vlen - 6'h01);
          next_st.out_valid = 1'b1;
          next_st.out_data = vif.rd_data;
          next_st.out_sop = 1'b0;
          next_st.out_eop = last;
          next_st.idx = last ? 6'h00 : st.idx + 6'h01;
          if (last) begin
            next_st.state = rsf_idle;
          end
        end
      end
      default: begin
        next_st.state = rsf_idle;
      end
    endcase
    next_st.desc_ready = (next_st.state == rsf_idle);
    next_st.pay_ready = (next_st.state == rsf_pay) && !next_st.out_valid;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign desc_ready = st.desc_ready;
  assign pay_ready = st.pay_ready;
  assign out_valid = st.out_valid;
  assign out_data = st.out_data;
  assign out_sop = st.out_sop;
  assign out_eop = st.out_eop;
  assign data_pw_divert = st.divert;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  localparam int HS = `RSF_HDR_STAT_LSB;
  localparam int TS = `RSF_TRL_STAT_LSB;

  sequence rng_take;
    take && rng_hit;
  endsequence

  chk_hdr_version: assert property (rng_take |=> st.sh[HS+7:HS+6] == 2'h0 && st.sh[HS+3:HS+2] == 2'h0
    && st.sh[TS+7:TS+6] == 2'h0 && st.state == rsf_hdr)
    else $error("version or reserved bits wrong");
  chk_rng_type: assert property (rng_take |=> st.sh[HS+`RSF_HS_TYPE] == $past(desc_initial))
    else $error("ranging type bit wrong");
  chk_no_payload: assert property (st.state == rsf_hdr && st.idx == `RSF_HDR_LAST && slot
    |=> st.state == (st.nopay ? rsf_trl : rsf_pay))
    else $error("payload presence not honoured");
  chk_hdr_check: assert property (rng_take |=> st.sh[HS+`RSF_HS_HDR_CHK]
    == ($past(desc_hdr_chk_fail) && !$past(desc_initial)))
    else $error("header check flag wrong");
  chk_crc_flag: assert property (rng_take |=> st.sh[HS+`RSF_HS_CRC] == $past(desc_crc_fail))
    else $error("crc flag wrong");
  chk_hdr_fields: assert property (rng_take |=> st.sh[HS-1:HS-51]
    == {1'b0, $past(desc_usage_code), $past(desc_service_id), $past(desc_minislot)})
    else $error("header fields misplaced");
  chk_trl_flags: assert property (rng_take |=> st.sh[TS+5:TS] == {$past(desc_mod_ratio_ok),
    $past(desc_time_ok), $past(desc_freq_ok), $past(desc_bin_ok), 1'b0, $past(desc_vendor)})
    else $error("trailer flags wrong");
  chk_burst_stat: assert property (rng_take |=> st.sh[TS-1:TS-8] == {$past(desc_reranging),
    $past(desc_pre_fail) || $past(desc_post_fail), $past(desc_post_fail), 2'h0, $past(desc_bin)})
    else $error("burst status wrong");
  chk_meas_fields: assert property (rng_take |=> st.sh[TS-25:TS-88] == {$past(desc_mod_ratio),
    $past(desc_pwr_err), $past(desc_freq_err), $past(desc_time_err)})
    else $error("measurement fields wrong");
  chk_vnd_len: assert property (st.vlen <= `RSF_VND_MAX)
    else $error("vendor length above ceiling");
  chk_vnd_count: assert property (st.state == rsf_vnd |-> st.vend && st.idx < st.vlen)
    else $error("vendor content overrun");
  chk_pw_route: assert property (take && !rng_hit |=> st.divert && st.state == rsf_idle)
    else $error("non-ranging burst framed");
  chk_one_unit: assert property (st.state != rsf_idle |-> !st.desc_ready)
    else $error("descriptor accepted mid frame");
  chk_sop_first: assert property (st.out_valid && st.out_sop |-> st.out_data[7:6] == 2'h0
    && $past(st.state) == rsf_hdr)
    else $error("frame does not open with header");

  cov_vendor_frame: cover property (st.state == rsf_vnd && slot && st.idx == st.vlen - 6'h01);
  cov_no_payload: cover property (rng_take ##1 st.nopay);
  cov_divert: cover property (st.divert);
  cov_payload_end: cover property (st.state == rsf_pay && st.pay_ready && pay_valid && pay_last);

endmodule

// ===== testbench/rsf_sink.sv
/*
  Packetiser-side model: accepts framer output bytes, prompt or stalling every other cycle.
  Assumes it shares sys_clk and resetn with the framer.
*/
`timescale 1ns/10ps

module rsf_sink (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // pacing control
  input wire logic slow,
  // framer output
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_sop,
  input wire logic out_eop,
  output logic out_ready,
  // accepted byte report, one cycle late
  output logic got_valid,
  output logic [7:0] got_data,
  output logic got_sop,
  output logic got_eop
);
  logic ph;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ph <= 1'b0;
      out_ready <= 1'b0;
      got_valid <= 1'b0;
      got_sop <= 1'b0;
      got_eop <= 1'b0;
    end else begin
      ph <= ~ph;
      out_ready <= !slow || ph;
      got_valid <= out_valid && out_ready;
      got_data <= out_data;
      got_sop <= out_valid && out_ready && out_sop;
      got_eop <= out_valid && out_ready && out_eop;
    end
  end
endmodule

// ===== testbench/tb_rsf_framer.sv
/*
  Self-checking bench of the ranging segment framer: whole frames compared byte by byte.
  Assumes rsf_pkg, rsf_framer and its vendor store are compiled first.
*/
`timescale 1ns/10ps

module tb_rsf_framer import rsf_pkg::*;;
  logic sys_clk, resetn, rng_pw_enable, desc_valid, desc_ready, desc_initial, desc_no_burst;
  logic desc_hdr_chk_fail, desc_crc_fail, desc_mod_ratio_ok, desc_freq_ok, desc_time_ok, desc_bin_ok;
  logic desc_reranging, desc_pre_fail, desc_post_fail, desc_vendor, vnd_wr_en, pay_valid, pay_last;
  logic pay_ready, out_valid, out_sop, out_eop, out_ready, data_pw_divert, slow;
  logic got_valid, got_sop, got_eop;
  logic [3:0] desc_usage_code;
  logic [13:0] desc_service_id;
  logic [31:0] desc_minislot, desc_time_err;
  logic [7:0] desc_mod_ratio, desc_pwr_err, vnd_wr_data, pay_data, out_data, got_data;
  logic [15:0] desc_freq_err;
  logic [2:0] desc_bin;
  logic [23:0] desc_org_id;
  logic [5:0] desc_vlen;
  logic [4:0] vnd_wr_addr;
  logic [7:0] got_q[$];
  logic [7:0] pay_q[$];
  int bad_count, n_tests, nsop, neop, sop_at, eop_at;

  rsf_framer u_dut (.*);

  rsf_sink u_sink (.sys_clk(sys_clk), .resetn(resetn), .slow(slow), .out_valid(out_valid),
    .out_data(out_data), .out_sop(out_sop), .out_eop(out_eop), .out_ready(out_ready),
    .got_valid(got_valid), .got_data(got_data), .got_sop(got_sop), .got_eop(got_eop));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // payload source follows the queue head
  always @(posedge sys_clk) begin
    if (pay_valid && pay_ready) void'(pay_q.pop_front());
    pay_valid <= pay_q.size() != 0;
    pay_data <= pay_q.size() != 0 ? pay_q[0] : 8'h00;
    pay_last <= pay_q.size() == 1;
  end

  always @(posedge sys_clk) begin
    if (got_valid) begin
      if (got_sop) begin
        nsop++;
        sop_at = got_q.size();
      end
      if (got_eop) begin
        neop++;
        eop_at = got_q.size();
      end
      got_q.push_back(got_data);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task summarize();
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic send(input logic ini, nob, hck, crc, vnd, input logic [3:0] ucode,
                      input logic [5:0] vl, input int np, input logic [7:0] s);
    logic [7:0] e[$];
    logic [55:0] h;
    logic pay;
    int n;
    int t;
    do @(posedge sys_clk); while (desc_ready !== 1'b1);
    got_q.delete();
    {nsop, neop} = '0;
    pay = ini | ~nob;
    desc_valid <= 1'b1;
    rng_pw_enable <= 1'b1;
    {desc_initial, desc_no_burst, desc_hdr_chk_fail, desc_crc_fail, desc_vendor} <= {ini, nob, hck, crc, vnd};
    {desc_usage_code, desc_vlen} <= {ucode, vl};
    {desc_mod_ratio_ok, desc_time_ok, desc_freq_ok, desc_bin_ok, desc_bin, desc_reranging} <= s;
    {desc_pre_fail, desc_post_fail} <= s[2:1];
    {desc_service_id, desc_minislot, desc_mod_ratio, desc_pwr_err, desc_freq_err, desc_time_err, desc_org_id} <=
      {s[5:0], s, {4{~s}}, s + 8'h11, ~s, s, 8'h80, s, 8'h7F, ~s, 8'h01, 8'hA5, s, ~s};
    for (n = 0; n < np && pay; n++) pay_q.push_back(s + 8'(n));
    @(posedge sys_clk);
    desc_valid <= 1'b0;
    h = {1'b0, desc_usage_code, desc_service_id, desc_minislot, 5'h00};
    e.push_back({2'b00, ini, nob & ~ini, 2'b00, hck & ~ini, crc});
    for (n = 6; n >= 0; n--) e.push_back(h[n*8+:8]);
    for (n = 0; n < np && pay; n++) e.push_back(s + 8'(n));
    t = e.size();
    e.push_back({2'b00, desc_mod_ratio_ok, desc_time_ok, desc_freq_ok, desc_bin_ok, 1'b0, vnd});
    e.push_back({desc_reranging, desc_pre_fail | desc_post_fail, desc_post_fail, 2'b00, desc_bin});
    e.push_back(8'h00);
    e.push_back(8'h00);
    e.push_back(desc_mod_ratio);
    e.push_back(desc_pwr_err);
    for (n = 1; n >= 0; n--) e.push_back(desc_freq_err[n*8+:8]);
    for (n = 3; n >= 0; n--) e.push_back(desc_time_err[n*8+:8]);
    if (vnd) begin
      for (n = 2; n >= 0; n--) e.push_back(desc_org_id[n*8+:8]);
      e.push_back({2'b00, vl > 6'h20 ? 6'h20 : vl});
      for (n = 0; n < (vl > 6'h20 ? 32 : int'(vl)); n++) e.push_back(8'(n) ^ 8'h96);
    end
    n = 0;
    while (neop == 0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (3) @(posedge sys_clk);
    check(got_q.size(), e.size());
    check(nsop, 1);
    check(neop, 1);
    check(sop_at, 0);
    check(eop_at, e.size() - 1);
    if (got_q.size() == e.size()) begin
      for (n = 0; n < e.size(); n++) check(got_q[n], e[n]);
      check(got_q[0][7:6], 2'b00);
      check(got_q[0][5], ini);
      check(got_q[0][4], nob & ~ini);
      check(got_q[0][1], hck & ~ini);
      check(got_q[0][0], crc);
      check(got_q[1][7:3], {1'b0, ucode});
      check(got_q[t][5], desc_mod_ratio_ok);
      check(got_q[t][0], vnd);
      check(got_q[t + 1][7], desc_reranging);
      check(got_q[t + 1][6:5], {desc_pre_fail | desc_post_fail, desc_post_fail});
      check(got_q[t + 1][2:0], desc_bin);
      check(got_q[t + 4], desc_mod_ratio);
      check(got_q[t + 5], desc_pwr_err);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task fill_store();
    int k;
    for (k = 0; k < 32; k++) begin
      @(posedge sys_clk);
      vnd_wr_en <= 1'b1;
      vnd_wr_addr <= 5'(k);
      vnd_wr_data <= 8'(k) ^ 8'h96;
    end
    @(posedge sys_clk);
    vnd_wr_en <= 1'b0;
  endtask

  task sc_initial();
    slow <= 1'b0;
    send(1, 1, 1, 1, 1, 4'h3, 6'h05, 4, 8'h5A);
  endtask

  task sc_fine_nob();
    slow <= 1'b1;
    send(0, 1, 1, 0, 0, 4'h4, 6'h07, 3, 8'hC3);
  endtask

  task sc_fine_pay();
    slow <= 1'b1;
    send(0, 0, 1, 1, 1, 4'h3, 6'h28, 2, 8'h0F);
  endtask

  task automatic sc_divert();
    logic [3:0] codes[6] = '{4'h0, 4'h2, 4'h5, 4'h9, 4'hF, 4'h3};
    int i;
    for (i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      desc_valid <= 1'b1;
      desc_usage_code <= codes[i];
      rng_pw_enable <= i != 5;
      @(posedge sys_clk);
      desc_valid <= 1'b0;
      @(posedge sys_clk);
      check(data_pw_divert, 1'b1);
      check(desc_ready, 1'b1);
      @(posedge sys_clk);
      check(data_pw_divert, 1'b0);
      check(out_valid, 1'b0);
      check(pay_ready, 1'b0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, rng_pw_enable, desc_valid, desc_initial, desc_no_burst, desc_hdr_chk_fail, desc_crc_fail} = '0;
    {desc_mod_ratio_ok, desc_freq_ok, desc_time_ok, desc_bin_ok, desc_reranging, desc_pre_fail} = '0;
    {desc_post_fail, desc_vendor, vnd_wr_en, pay_valid, pay_last, slow} = '0;
    {desc_usage_code, desc_service_id, desc_minislot, desc_time_err, desc_mod_ratio, desc_pwr_err} = '0;
    {vnd_wr_data, pay_data, desc_freq_err, desc_bin, desc_org_id, desc_vlen, vnd_wr_addr} = '0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    fill_store();
    sc_initial();
    sc_fine_nob();
    sc_fine_pay();
    sc_divert();
    summarize();
  end

  // watchdog
  initial begin
    #400000;
    bad_count++;
    summarize();
  end
endmodule
